// ### core/fvr_ctrl.sv
// Module: fixed reference control register with ready-flag hardware
// ----------------------------------------
// Contract
// - Control bit 7 turns the fixed reference on when set, off when cleared.
// - Ready flag, bit 6, sets only after reference and amplifiers have stabilized.
// - Ready flag reads zero while unstable or while the reference is disabled.
// - On the regulator variant, the ready flag always reads one.
// - Bit 5 enables the temperature indicator when set.
// - Bit 4 selects temperature high range when set, low range when clear.
// - Comparator gain bits 3:2: 11=4x, 10=2x, 01=1x, 00=buffer off.
// - ADC gain bits 1:0: 11=4x, 10=2x, 01=1x, 00=buffer off.
// - All writable control bits clear to zero on every reset.
// ----------------------------------------
`timescale 1ns/100ps
module fvr_ctrl #(
   parameter bit REGULATOR_VARIANT = 1'b0
) (
   input  wire logic                         sys_clk,
   input  wire logic                         rstn,
   input  wire fvr_pkg::fvr_bus_req_type     bus_req,
   output      logic [7:0]                   bus_rdata,
   input  wire logic                         ref_stable_in,
   output      fvr_pkg::fvr_analog_ctrl_type analog_ctrl,
   output      logic                         ref_ready
);
   import fvr_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic fvr_gain_type decode_gain(input logic [1:0] code);
      fvr_gain_type g;
      g = FVR_GAIN_OFF;
      unique case (code)
         GAIN_X4: g = FVR_GAIN_4X;
         GAIN_X2: g = FVR_GAIN_2X;
         GAIN_X1: g = FVR_GAIN_1X;
         GAIN_OFF: g = FVR_GAIN_OFF;
      endcase
      return g;
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0]              ctrl_r, ctrl_nxt;
   logic [SETTLE_CNT_W-1:0] settle_r, settle_nxt;
   logic                    ready_r, ready_nxt;
   logic                    stable_s1_r, stable_s2_r;
   logic [7:0]              rdata_r, rdata_nxt;
   logic                    ready_view;

   // Analog stable indication comes from outside the clock domain
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         stable_s1_r <= 1'b0;
         stable_s2_r <= 1'b0;
      end else begin
         stable_s1_r <= ref_stable_in;
         stable_s2_r <= stable_s1_r;
      end
   end

   // ----------------------------------------
   // Control register and ready timer
   // ----------------------------------------
   always_comb begin
      ctrl_nxt   = ctrl_r;
      settle_nxt = settle_r;
      ready_nxt  = ready_r;
      if (bus_req.wr && bus_req.addr == REF_CONTROL_ADDR) begin
         ctrl_nxt = bus_req.wdata & WRITE_MASK;
      end
      if (!ctrl_r[REF_ENABLE_BIT]) begin
         settle_nxt = '0;
         ready_nxt  = 1'b0;
      end else if (settle_r != SETTLE_CNT_W'(SETTLE_CYCLES)) begin
         settle_nxt = settle_r + 1'b1;
         ready_nxt  = 1'b0;
      end else begin
         ready_nxt = stable_s2_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r   <= REF_CONTROL_RESET;
         settle_r <= '0;
         ready_r  <= 1'b0;
         rdata_r  <= 8'h00;
      end else begin
         ctrl_r   <= ctrl_nxt;
         settle_r <= settle_nxt;
         ready_r  <= ready_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   assign ready_view = REGULATOR_VARIANT ? 1'b1 : ready_r;

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            REF_CONTROL_ADDR: begin
               rdata_nxt                = ctrl_r;
               rdata_nxt[REF_READY_BIT] = ready_view;
            end
            REF_STATUS_ADDR: rdata_nxt = {7'h00, stable_s2_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   assign bus_rdata = rdata_r;
   assign ref_ready = ready_view;

   // ----------------------------------------
   // Analog controls
   // ----------------------------------------
   always_comb begin
      analog_ctrl.ref_enable        = ctrl_r[REF_ENABLE_BIT];
      analog_ctrl.temp_sense_enable = ctrl_r[TEMP_ENABLE_BIT];
      analog_ctrl.temp_range_select = ctrl_r[TEMP_RANGE_BIT];
      analog_ctrl.comparator_gain   = decode_gain(ctrl_r[CMP_GAIN_LSB +: 2]);
      analog_ctrl.adc_gain          = decode_gain(ctrl_r[ADC_GAIN_LSB +: 2]);
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_enable_write;
      bus_req.wr && bus_req.addr == REF_CONTROL_ADDR && bus_req.wdata[REF_ENABLE_BIT];
   endsequence

   AST_ENABLE_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_enable_write |=> analog_ctrl.ref_enable)
      else $error("reference enable did not follow write");
   AST_READY_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!REGULATOR_VARIANT && !analog_ctrl.ref_enable) |=> !ref_ready)
      else $error("ready set while reference disabled");
   AST_READY_WAITS: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!REGULATOR_VARIANT && $rose(ref_ready)) |->
      $past(settle_r) == SETTLE_CNT_W'(SETTLE_CYCLES) && $past(stable_s2_r))
      else $error("ready rose before settling");
   AST_READY_FIXED: assert property (@(posedge sys_clk) disable iff (!rstn)
      REGULATOR_VARIANT |-> ref_ready)
      else $error("regulator variant ready not one");
   AST_TEMP_BITS: assert property (@(posedge sys_clk) disable iff (!rstn)
      (bus_req.wr && bus_req.addr == REF_CONTROL_ADDR) |=>
      analog_ctrl.temp_sense_enable == $past(bus_req.wdata[TEMP_ENABLE_BIT]))
      else $error("temperature enable mismatch");
   AST_RANGE_BIT: assert property (@(posedge sys_clk) disable iff (!rstn)
      (bus_req.wr && bus_req.addr == REF_CONTROL_ADDR) |=>
      analog_ctrl.temp_range_select == $past(bus_req.wdata[TEMP_RANGE_BIT]))
      else $error("temperature range mismatch");
   AST_CMP_GAIN: assert property (@(posedge sys_clk) disable iff (!rstn)
      (bus_req.wr && bus_req.addr == REF_CONTROL_ADDR && bus_req.wdata[3:2] == GAIN_X4) |=>
      analog_ctrl.comparator_gain == FVR_GAIN_4X)
      else $error("comparator gain decode wrong");
   AST_ADC_GAIN: assert property (@(posedge sys_clk) disable iff (!rstn)
      (bus_req.wr && bus_req.addr == REF_CONTROL_ADDR && bus_req.wdata[1:0] == GAIN_OFF) |=>
      analog_ctrl.adc_gain == FVR_GAIN_OFF)
      else $error("adc gain decode wrong");
   AST_NO_READY_STORE: assert property (@(posedge sys_clk) disable iff (!rstn)
      !ctrl_r[REF_READY_BIT])
      else $error("ready position stored a value");
   AST_READ_READY: assert property (@(posedge sys_clk) disable iff (!rstn)
      (bus_req.rd && bus_req.addr == REF_CONTROL_ADDR) |=> bus_rdata[REF_READY_BIT] == $past(ready_view))
      else $error("read ready bit mismatch");

   // Further register and ready-flag checks
   sequence s_ctrl_write;
      bus_req.wr && bus_req.addr == REF_CONTROL_ADDR;
   endsequence

   sequence s_enable_clear;
      s_ctrl_write ##0 !bus_req.wdata[REF_ENABLE_BIT];
   endsequence

   sequence s_ready_poke;
      s_ctrl_write ##0 (!REGULATOR_VARIANT && bus_req.wdata[REF_READY_BIT] && !bus_req.wdata[REF_ENABLE_BIT]);
   endsequence

   AST_ENABLE_CLEARS: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_enable_clear |=> !analog_ctrl.ref_enable)
      else $error("reference enable did not clear");
   AST_CMP_GAIN_X2: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_ctrl_write ##0 (bus_req.wdata[CMP_GAIN_LSB +: 2] == GAIN_X2) |=>
      analog_ctrl.comparator_gain == FVR_GAIN_2X)
      else $error("comparator gain 2x decode wrong");
   AST_CMP_GAIN_X1: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_ctrl_write ##0 (bus_req.wdata[CMP_GAIN_LSB +: 2] == GAIN_X1) |=>
      analog_ctrl.comparator_gain == FVR_GAIN_1X)
      else $error("comparator gain 1x decode wrong");
   AST_CMP_GAIN_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_ctrl_write ##0 (bus_req.wdata[CMP_GAIN_LSB +: 2] == GAIN_OFF) |=>
      analog_ctrl.comparator_gain == FVR_GAIN_OFF)
      else $error("comparator buffer not off");
   AST_ADC_GAIN_X4: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_ctrl_write ##0 (bus_req.wdata[ADC_GAIN_LSB +: 2] == GAIN_X4) |=>
      analog_ctrl.adc_gain == FVR_GAIN_4X)
      else $error("adc gain 4x decode wrong");
   AST_ADC_GAIN_X2: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_ctrl_write ##0 (bus_req.wdata[ADC_GAIN_LSB +: 2] == GAIN_X2) |=>
      analog_ctrl.adc_gain == FVR_GAIN_2X)
      else $error("adc gain 2x decode wrong");
   AST_ADC_GAIN_X1: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_ctrl_write ##0 (bus_req.wdata[ADC_GAIN_LSB +: 2] == GAIN_X1) |=>
      analog_ctrl.adc_gain == FVR_GAIN_1X)
      else $error("adc gain 1x decode wrong");
   AST_READY_NOT_WRITTEN: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_ready_poke |=> ##1 !ref_ready)
      else $error("ready flag took a written value");
   AST_READY_DROPS: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!REGULATOR_VARIANT && !stable_s2_r) |=> !ref_ready)
      else $error("ready held while reference unstable");
   AST_READY_SETTLED: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!REGULATOR_VARIANT && ref_ready) |-> settle_r == SETTLE_CNT_W'(SETTLE_CYCLES))
      else $error("ready set with settle timer short");
   AST_STATUS_READ: assert property (@(posedge sys_clk) disable iff (!rstn)
      (bus_req.rd && bus_req.addr == REF_STATUS_ADDR) |=> bus_rdata == {7'h00, $past(stable_s2_r)})
      else $error("status read mismatch");

endmodule

// ### core/fvr_pkg.sv
// Package: register map, field layout and types of the fixed reference control block
package fvr_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] REF_CONTROL_ADDR  = 4'h0;
   localparam logic [3:0] REF_STATUS_ADDR   = 4'h1;
   localparam logic [7:0] REF_CONTROL_RESET = 8'h00;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int REF_ENABLE_BIT   = 7;
   localparam int REF_READY_BIT    = 6;
   localparam int TEMP_ENABLE_BIT  = 5;
   localparam int TEMP_RANGE_BIT   = 4;
   localparam int CMP_GAIN_LSB     = 2;
   localparam int ADC_GAIN_LSB     = 0;
   localparam logic [7:0] WRITE_MASK = 8'hBF;

   // ----------------------------------------
   // Gain codes and timing
   // ----------------------------------------
   localparam logic [1:0] GAIN_OFF = 2'h0;
   localparam logic [1:0] GAIN_X1  = 2'h1;
   localparam logic [1:0] GAIN_X2  = 2'h2;
   localparam logic [1:0] GAIN_X4  = 2'h3;
   localparam int SETTLE_NS       = 25000;
   localparam int CLK_PERIOD_NS   = 25;
   localparam int SETTLE_CYCLES   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CNT_W    = 10;

   typedef enum logic [1:0] {
      FVR_GAIN_OFF,
      FVR_GAIN_1X,
      FVR_GAIN_2X,
      FVR_GAIN_4X
   } fvr_gain_type;

   typedef struct packed {
      logic         ref_enable;
      logic         temp_sense_enable;
      logic         temp_range_select;
      fvr_gain_type comparator_gain;
      fvr_gain_type adc_gain;
   } fvr_analog_ctrl_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } fvr_bus_req_type;

endpackage

// ### tb/test_fixed_reference_control.sv
// Testbench: register access, gain decode and ready flag of the fixed reference control block
`timescale 1ns/100ps
module test_fixed_reference_control;
   import fvr_pkg::*;
   logic                sys_clk = 1'b0;
   logic                rstn, ref_stable_in, ref_ready, reg_ready;
   fvr_bus_req_type     bus_req;
   logic [7:0]          bus_rdata, rd_val;
   fvr_analog_ctrl_type analog_ctrl;
   int                  error_cnt = 0, n_tests = 0, cyc = 0;
   fvr_ctrl #(.REGULATOR_VARIANT(1'b0)) DUT (.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .ref_stable_in(ref_stable_in), .analog_ctrl(analog_ctrl), .ref_ready(ref_ready));
   fvr_ctrl #(.REGULATOR_VARIANT(1'b1)) DUT_REG (.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req),
      .bus_rdata(), .ref_stable_in(ref_stable_in), .analog_ctrl(), .ref_ready(reg_ready));
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         give_verdict();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
      end
   endtask
   task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk) bus_req.wr <= 1'b0;
      #1;
   endtask
   task automatic bus_read(input logic [3:0] a);
      @(posedge sys_clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk) bus_req.rd <= 1'b0;
      #1 rd_val = bus_rdata;
   endtask
   task automatic wait_ready(input int n);
      for (int i = 0; i < n && ref_ready !== 1'b1; i++) @(posedge sys_clk);
      #1;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_state();
      check({1'b0, analog_ctrl}, 8'h00, "outputs after reset");
      check({7'h00, ref_ready}, 8'h00, "ready after reset");
      check({7'h00, reg_ready}, 8'h01, "regulator ready");
      bus_read(REF_CONTROL_ADDR);
      check(rd_val, 8'h00, "control after reset");
   endtask
   task automatic t_fields();
      logic [1:0] g;
      for (int i = 0; i < 4; i++) begin
         g = i[1:0];
         bus_write(REF_CONTROL_ADDR, {2'b01, g[0], g[1], g, ~g});
         check({1'b0, analog_ctrl}, {2'b00, g[0], g[1], g, ~g}, "decode");
         bus_read(REF_CONTROL_ADDR);
         check(rd_val, {2'b00, g[0], g[1], g, ~g}, "readback");
      end
      bus_write(4'hF, 8'hFF);
      bus_write(REF_STATUS_ADDR, 8'hFF);
      bus_read(4'hF);
      check(rd_val, 8'h00, "unmapped read");
      bus_read(REF_CONTROL_ADDR);
      check(rd_val, 8'h3C, "unmapped write ignored");
   endtask
   task automatic t_ready(input logic stable);
      @(posedge sys_clk) ref_stable_in <= stable;
      bus_write(REF_CONTROL_ADDR, 8'h80);
      check({7'h00, analog_ctrl.ref_enable}, 8'h01, "enable");
      repeat (SETTLE_CYCLES) @(posedge sys_clk);
      #1;
      check({7'h00, ref_ready}, 8'h00, "ready too early");
      @(posedge sys_clk) #1;
      check({7'h00, ref_ready}, {7'h00, stable}, "ready settle");
      bus_read(REF_STATUS_ADDR);
      check(rd_val, {7'h00, stable}, "status");
      if (!stable) begin
         @(posedge sys_clk) ref_stable_in <= 1'b1;
         wait_ready(8);
         check({7'h00, ref_ready}, 8'h01, "ready after stable");
      end
      bus_read(REF_CONTROL_ADDR);
      check(rd_val, 8'hC0, "ready in control");
      check({7'h00, reg_ready}, 8'h01, "regulator ready");
      bus_write(REF_CONTROL_ADDR, 8'h7F);
      @(posedge sys_clk) #1;
      check({7'h00, ref_ready}, 8'h00, "ready after disable");
      check({1'b0, analog_ctrl}, 8'h3F, "disable keeps fields");
      bus_write(REF_CONTROL_ADDR, 8'h30);
      check({1'b0, analog_ctrl}, 8'h30, "gains cleared when off");
   endtask
   task automatic t_mid_reset();
      @(posedge sys_clk) rstn <= 1'b0;
      @(posedge sys_clk) #1;
      check({1'b0, analog_ctrl}, 8'h00, "outputs in reset");
      check({7'h00, ref_ready}, 8'h00, "ready in reset");
      check({7'h00, reg_ready}, 8'h01, "regulator ready in reset");
      @(posedge sys_clk) rstn <= 1'b1;
      bus_read(REF_CONTROL_ADDR);
      check(rd_val, 8'h00, "control after second reset");
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      ref_stable_in = 1'b0;
      bus_req = '0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset_state();
      t_fields();
      t_ready(1'b1);
      t_ready(1'b0);
      t_mid_reset();
      give_verdict();
   end
endmodule
